// file: hw/mmd_consts.vh
// memory map decoder constants: offsets, reset values, region limits
// assumes inclusion by both design files
`ifndef MMD_CONSTS_VH
`define MMD_CONSTS_VH
// register byte offsets on the bus
`define MMD_OFF_ROM_SIZE   12'h000
`define MMD_OFF_XRAM_SIZE  12'h004
`define MMD_OFF_BANK       12'h008
`define MMD_OFF_CTRL       12'h00C
`define MMD_OFF_STATUS     12'h010
`define MMD_OFF_LOOKUP     12'h014
// reset values
`define MMD_ROM_SIZE_RST   8'hCF
`define MMD_XRAM_SIZE_RST  8'h0C
`define MMD_BANK_RST       3'h0
// rom size codes
`define MMD_ROM_16K        8'h04
`define MMD_ROM_24K        8'hC6
`define MMD_ROM_32K        8'hC8
`define MMD_ROM_48K        8'hCC
`define MMD_ROM_60K        8'hCF
// rom end addresses
`define MMD_END_16K        16'h3FFF
`define MMD_END_24K        16'h5FFF
`define MMD_END_32K        16'h7FFF
`define MMD_END_48K        16'hBFFF
`define MMD_END_60K        16'hEFFF
// fixed areas
`define MMD_VEC_LO         16'h0000
`define MMD_VEC_HI         16'h003F
`define MMD_VEC_RESET      16'h0000
`define MMD_VEC_LVI        16'h0004
`define MMD_VEC_LAST       16'h0034
`define MMD_TABLE_INDIRECT_CALL_LO       16'h0040
`define MMD_TABLE_INDIRECT_CALL_HI       16'h007F
`define MMD_OPT_LO         16'h0080
`define MMD_OPT_HI         16'h0084
`define MMD_SID_LO         16'h0085
`define MMD_SID_HI         16'h008E
`define MMD_SWAP_OFS       16'h1000
`define MMD_SHORT_DIRECT_CALL_LO       16'h0800
`define MMD_SHORT_DIRECT_CALL_HI       16'h0FFF
`define MMD_BOOT0_HI       16'h0FFF
`define MMD_WIN_LO         16'h8000
`define MMD_WIN_HI         16'hBFFF
`define MMD_COMMON_HI      16'h7FFF
// ram and special register floors, expansion ram top
`define MMD_HSRAM_LO       16'hFB00
`define MMD_SFR_LO         16'hFF00
`define MMD_XRAM_TOP       16'hF7FF
// expansion ram size codes and the floor each one opens
`define MMD_XRAM_CODE_1K   8'h0A
`define MMD_XRAM_CODE_2K   8'h08
`define MMD_XRAM_CODE_4K   8'h04
`define MMD_XRAM_CODE_6K   8'h00
`define MMD_XRAM_LO_1K     16'hF400
`define MMD_XRAM_LO_2K     16'hF000
`define MMD_XRAM_LO_4K     16'hE800
`define MMD_XRAM_LO_6K     16'hE000
`define MMD_XRAM_LO_NONE   16'hF800
// highest bank number, four or six bank parts
`define MMD_BANK_MAX_FOUR  3'h3
`define MMD_BANK_MAX_SIX   3'h5
// region codes
`define MMD_RG_NONE        4'h0
`define MMD_RG_VEC         4'h1
`define MMD_RG_TABLE_INDIRECT_CALL       4'h2
`define MMD_RG_OPT         4'h3
`define MMD_RG_SID         4'h4
`define MMD_RG_SHORT_DIRECT_CALL       4'h5
`define MMD_RG_ROM         4'h6
`define MMD_RG_BANK        4'h7
`define MMD_RG_XRAM        4'h8
`define MMD_RG_HSRAM       4'h9
`define MMD_RG_SFR         4'hA
// control bits
`define MMD_CTRL_SWAP      0
`define MMD_CTRL_SECURE    1
`define MMD_CTRL_BANKED    2
`define MMD_CTRL_DEBUG     3
`define MMD_CTRL_SIX       4
`define MMD_CTRL_W         5
`endif

// file: hw/mmd_region.v
// one address classifier: region code, rom flag and rom end address
// assumes static size registers during a lookup, synchronous inputs
`timescale 1ns/1ps
`default_nettype none
`include "mmd_consts.vh"
module mmd_region (
  // configuration
  input  wire [7:0]  rom_size_select,
  input  wire [7:0]  expansion_ram_size_select,
  input  wire [2:0]  bank,
  input  wire        banked,
  input  wire        swap,
  input  wire        debug_part,
  // address
  input  wire [15:0] addr,
  // result
  output reg  [3:0]  region,
  output reg         is_rom,
  output reg  [15:0] rom_end
);
  reg [15:0] xram_lo;
  always @* begin
    case (rom_size_select)
      `MMD_ROM_16K: rom_end = `MMD_END_16K;
      `MMD_ROM_24K: rom_end = `MMD_END_24K;
      `MMD_ROM_32K: rom_end = `MMD_END_32K;
      `MMD_ROM_48K: rom_end = `MMD_END_48K;
      `MMD_ROM_60K: rom_end = `MMD_END_60K;
      default:      rom_end = `MMD_END_16K;
    endcase
    // expansion ram: codes 0A, 08, 04, 00 open 1, 2, 4, 6 KB below F800, others none
    case (expansion_ram_size_select)
      `MMD_XRAM_CODE_1K: xram_lo = `MMD_XRAM_LO_1K;
      `MMD_XRAM_CODE_2K: xram_lo = `MMD_XRAM_LO_2K;
      `MMD_XRAM_CODE_4K: xram_lo = `MMD_XRAM_LO_4K;
      `MMD_XRAM_CODE_6K: xram_lo = `MMD_XRAM_LO_6K;
      default:           xram_lo = `MMD_XRAM_LO_NONE;
    endcase
  end
  always @* begin
    region = `MMD_RG_NONE;
    is_rom = 1'b0;
    if (addr >= `MMD_SFR_LO) begin
      region = `MMD_RG_SFR;
    end else if (addr >= `MMD_HSRAM_LO) begin
      region = `MMD_RG_HSRAM;
    end else if (addr >= xram_lo && addr <= `MMD_XRAM_TOP) begin
      region = `MMD_RG_XRAM;
    end else if (banked && addr >= `MMD_WIN_LO && addr <= `MMD_WIN_HI) begin
      region = `MMD_RG_BANK;
      is_rom = 1'b1;
    end else if (addr <= rom_end && !(banked && addr > `MMD_END_48K)) begin
      is_rom = 1'b1;
      if (addr <= `MMD_VEC_HI)
        region = `MMD_RG_VEC;
      else if (addr <= `MMD_TABLE_INDIRECT_CALL_HI)
        region = `MMD_RG_TABLE_INDIRECT_CALL;
      else if (addr <= `MMD_OPT_HI)
        region = `MMD_RG_OPT;
      else if (debug_part && addr <= `MMD_SID_HI)
        region = `MMD_RG_SID;
      else if (swap && addr >= (`MMD_OPT_LO + `MMD_SWAP_OFS)
               && addr <= (`MMD_OPT_HI + `MMD_SWAP_OFS))
        region = `MMD_RG_OPT;
      else if (swap && debug_part && addr >= (`MMD_SID_LO + `MMD_SWAP_OFS)
               && addr <= (`MMD_SID_HI + `MMD_SWAP_OFS))
        region = `MMD_RG_SID;
      else if (addr >= `MMD_SHORT_DIRECT_CALL_LO && addr <= `MMD_SHORT_DIRECT_CALL_HI)
        region = `MMD_RG_SHORT_DIRECT_CALL;
      else
        region = `MMD_RG_ROM;
    end
  end
endmodule
`default_nettype wire

// file: hw/mmd_top.v
// memory map decoder: ahb-lite register slave plus fetch/data decode
// assumes one ahb-lite master, single word transfers, core clock hclk
//
// How it works
// - full 16-bit, 64 KB address decode
// - size registers reset to CF and 0C
// - flat rom ends at size-dependent limit
// - banked: 32 KB common plus window
// - 0000-003F decoded as vector table
// - vector low byte even, high odd
// - every reset source uses vector 0000
// - interrupt slot address from source index
// - 0040-007F is table call area
// - option bytes, duplicated under boot swap
// - debug id area, duplicated under swap
// - short call targets only 0800-0FFF
// - secure setting blocks boot 0 writes
// - bank register selects window bank
`timescale 1ns/1ps
`default_nettype none
`include "mmd_consts.vh"
module mmd_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // core fetch and data address
  input  wire [15:0] core_addr,
  input  wire        core_valid,
  input  wire        core_write,
  input  wire        short_direct_call,
  // vector request
  input  wire        vector_req,
  input  wire [4:0]  vector_src,
  // decode result
  output reg  [3:0]  region,
  output reg         rom_sel,
  output reg  [16:0] rom_addr,
  output reg         write_blocked,
  output reg         call_fault,
  output reg  [15:0] vector_addr,
  output reg         vector_valid
);
  reg  [7:0]  rom_size_select;
  reg  [7:0]  expansion_ram_size_select;
  reg  [2:0]  bank;
  reg  [`MMD_CTRL_W-1:0] ctrl;
  reg         order_error;
  reg  [15:0] lookup_addr;
  reg         ph_act;
  reg         ph_wr;
  reg  [11:0] ph_addr;
  reg  [3:0]  lookup_region;
  wire [3:0]  dec_region;
  wire        dec_rom;
  wire [15:0] rom_end;
  wire [3:0]  lk_region;
  wire        lk_rom;
  wire [15:0] lk_end;
  wire        banked = ctrl[`MMD_CTRL_BANKED];
  wire        swap   = ctrl[`MMD_CTRL_SWAP];
  wire        debug_part = ctrl[`MMD_CTRL_DEBUG];
  wire [2:0]  bank_max = ctrl[`MMD_CTRL_SIX] ? `MMD_BANK_MAX_SIX : `MMD_BANK_MAX_FOUR;
  wire        take = hsel & hready & htrans[1];
  reg  [31:0] next_rdata;
  reg  [15:0] next_vec;
  reg  [16:0] next_rom_addr;

  // decode of the live core address
  mmd_region u_core (
    .rom_size_select           (rom_size_select),
    .expansion_ram_size_select (expansion_ram_size_select),
    .bank                      (bank),
    .banked                    (banked),
    .swap                      (swap),
    .debug_part                (debug_part),
    .addr                      (core_addr),
    .region                    (dec_region),
    .is_rom                    (dec_rom),
    .rom_end                   (rom_end)
  );

  // software probe of any address, readable over the bus
  mmd_region u_probe (
    .rom_size_select           (rom_size_select),
    .expansion_ram_size_select (expansion_ram_size_select),
    .bank                      (bank),
    .banked                    (banked),
    .swap                      (swap),
    .debug_part                (debug_part),
    .addr                      (lookup_addr),
    .region                    (lk_region),
    .is_rom                    (lk_rom),
    .rom_end                   (lk_end)
  );

  // address phase capture; slave is always zero wait
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_act    <= 1'b0;
      ph_wr     <= 1'b0;
      ph_addr   <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        ph_act  <= take;
        ph_wr   <= hwrite;
        ph_addr <= haddr;
      end
    end
  end

  // register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_size_select           <= `MMD_ROM_SIZE_RST;
      expansion_ram_size_select <= `MMD_XRAM_SIZE_RST;
      bank        <= `MMD_BANK_RST;
      ctrl        <= {`MMD_CTRL_W{1'b0}};
      order_error <= 1'b0;
      lookup_addr <= 16'h0000;
    end else if (ph_act && ph_wr) begin
      case (ph_addr)
        `MMD_OFF_ROM_SIZE: begin
          rom_size_select <= hwdata[7:0];
        end
        `MMD_OFF_XRAM_SIZE: begin
          expansion_ram_size_select <= hwdata[7:0];
          // ram sized while rom still at reset value: order or overlap slip
          if (rom_size_select == `MMD_ROM_SIZE_RST && hwdata[7:0] != `MMD_XRAM_SIZE_RST)
            order_error <= 1'b1;
        end
        `MMD_OFF_BANK: begin
          // out of range bank requests are ignored
          if (hwdata[2:0] <= bank_max)
            bank <= hwdata[2:0];
        end
        `MMD_OFF_CTRL: begin
          ctrl <= hwdata[`MMD_CTRL_W-1:0];
        end
        `MMD_OFF_STATUS: begin
          if (hwdata[0])
            order_error <= 1'b0;
        end
        `MMD_OFF_LOOKUP: begin
          lookup_addr <= hwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lookup_region <= `MMD_RG_NONE;
    else
      lookup_region <= lk_region;
  end

  // read mux, registered at address phase so data stands next cycle
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr)
      `MMD_OFF_ROM_SIZE:  next_rdata = {24'h000000, rom_size_select};
      `MMD_OFF_XRAM_SIZE: next_rdata = {24'h000000, expansion_ram_size_select};
      `MMD_OFF_BANK:      next_rdata = {29'h00000000, bank};
      `MMD_OFF_CTRL:      next_rdata = {27'h0000000, ctrl};
      `MMD_OFF_STATUS:    next_rdata = {15'h0000, rom_end, order_error};
      `MMD_OFF_LOOKUP:    next_rdata = {11'h000, lk_rom, lookup_region, lookup_addr};
      default:            next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (take && !hwrite)
      hrdata <= next_rdata;
  end

  // vector slot: 0000 for reset, else 0004 + 2*(source-1), cap at last slot
  always @* begin
    if (vector_src == 5'h00)
      next_vec = `MMD_VEC_RESET;
    else
      next_vec = `MMD_VEC_LVI + {10'h000, vector_src - 5'h01, 1'b0};
    if (next_vec > `MMD_VEC_LAST)
      next_vec = `MMD_VEC_LAST;
  end

  // flat rom offset; window maps to 8000 + bank*16K beyond the common area
  always @* begin
    if (dec_region == `MMD_RG_BANK)
      next_rom_addr = {bank, core_addr[13:0]} + {1'b0, `MMD_WIN_LO};
    else
      next_rom_addr = {1'b0, core_addr};
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      region        <= `MMD_RG_NONE;
      rom_sel       <= 1'b0;
      rom_addr      <= 17'h00000;
      write_blocked <= 1'b0;
      call_fault    <= 1'b0;
      vector_addr   <= `MMD_VEC_RESET;
      vector_valid  <= 1'b0;
    end else begin
      region   <= core_valid ? dec_region : `MMD_RG_NONE;
      rom_sel  <= core_valid & dec_rom;
      rom_addr <= next_rom_addr;
      // boot cluster 0 is 0000-0FFF
      write_blocked <= core_valid & core_write & ctrl[`MMD_CTRL_SECURE]
                       & (core_addr <= `MMD_BOOT0_HI);
      call_fault <= core_valid & short_direct_call
                    & (core_addr < `MMD_SHORT_DIRECT_CALL_LO || core_addr > `MMD_SHORT_DIRECT_CALL_HI);
      vector_valid <= vector_req;
      // low byte at even slot address, high at the next odd one
      if (vector_req)
        vector_addr <= next_vec;
    end
  end
endmodule
`default_nettype wire

// file: testbench/mmd_top_props.sv
// checker for the decode and vector outputs of mmd_top
// assumes bind onto mmd_top, single clock hclk
`timescale 1ns/1ps
`default_nettype none
module mmd_top_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [15:0] core_addr,
  input wire logic        core_valid,
  input wire logic        core_write,
  input wire logic        short_direct_call,
  input wire logic        vector_req,
  input wire logic [4:0]  vector_src,
  input wire logic [3:0]  region,
  input wire logic        rom_sel,
  input wire logic [16:0] rom_addr,
  input wire logic        write_blocked,
  input wire logic        call_fault,
  input wire logic [15:0] vector_addr,
  input wire logic        vector_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_vec_area: assert property (
    core_valid && core_addr <= 16'h003F |=> region == 4'h1) else $error("vector area miss");
  a_table_area: assert property (
    core_valid && core_addr >= 16'h0040 && core_addr <= 16'h007F |=> region == 4'h2)
    else $error("call table area miss");
  a_option_area: assert property (
    core_valid && core_addr >= 16'h0080 && core_addr <= 16'h0084 |=> region == 4'h3)
    else $error("option area miss");
  a_call_range: assert property (
    core_valid && short_direct_call |=>
    call_fault == ($past(core_addr) < 16'h0800 || $past(core_addr) > 16'h0FFF))
    else $error("short call fault wrong");
  a_block_cause: assert property (
    write_blocked |-> $past(core_write) && $past(core_addr) <= 16'h0FFF)
    else $error("write blocked without cause");
  a_reset_vector: assert property (
    vector_req && vector_src == 5'h00 |=> vector_valid && vector_addr == 16'h0000)
    else $error("reset vector wrong");
  a_first_slot: assert property (
    vector_req && vector_src == 5'h01 |=> vector_valid && vector_addr == 16'h0004)
    else $error("first slot wrong");
  a_slot_even: assert property (
    vector_valid |-> vector_addr[0] == 1'b0) else $error("vector slot odd");
  a_slot_hold: assert property (
    !vector_req |=> $stable(vector_addr)) else $error("vector address moved");
  a_rom_offset: assert property (
    region == 4'h6 |-> rom_sel && rom_addr == {1'b0, $past(core_addr)})
    else $error("flat rom offset wrong");
endmodule
bind mmd_top mmd_top_props mmd_top_props_inst (
  .hclk(hclk), .hresetn(hresetn), .core_addr(core_addr), .core_valid(core_valid),
  .core_write(core_write), .short_direct_call(short_direct_call),
  .vector_req(vector_req), .vector_src(vector_src), .region(region), .rom_sel(rom_sel),
  .rom_addr(rom_addr), .write_blocked(write_blocked), .call_fault(call_fault),
  .vector_addr(vector_addr), .vector_valid(vector_valid));
`default_nettype wire

// file: testbench/mmd_core_model.sv
// processor core model: fetch/data addresses and vector requests
// assumes tasks called from the bench, one request at a time
`timescale 1ns/1ps
`default_nettype none
module mmd_core_model (
  input  wire logic        hclk,
  output logic      [15:0] core_addr,
  output logic             core_valid,
  output logic             core_write,
  output logic             short_direct_call,
  output logic             vector_req,
  output logic      [4:0]  vector_src
);
  initial begin
    {core_addr, core_valid, core_write, short_direct_call, vector_req, vector_src} = '0;
  end
  // full 16-bit address, result read one edge later
  task access(input logic [15:0] a, input logic w, input logic c);
    @(posedge hclk);
    core_addr <= a;
    core_valid <= 1'b1;
    core_write <= w;
    short_direct_call <= c;
    @(posedge hclk);
    #1;
  endtask
  task vec(input logic [4:0] s);
    @(posedge hclk);
    vector_req <= 1'b1;
    vector_src <= s;
    @(posedge hclk);
    vector_req <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_memory_map_decoder.sv
// bench for mmd_top: ahb-lite register master plus core model
// assumes zero-wait slave, decode outputs one edge after the address
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_decoder;
  logic        hclk, hresetn, hsel, hwrite;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, core_valid, core_write, short_call, vector_req;
  wire  [15:0] core_addr, vector_addr;
  wire  [4:0]  vector_src;
  wire  [3:0]  region;
  wire  [16:0] rom_addr;
  wire         rom_sel, write_blocked, call_fault, vector_valid;
  int          bad_count, tests_run;
  mmd_core_model mmd_core_model_inst (.hclk(hclk), .core_addr(core_addr),
    .core_valid(core_valid), .core_write(core_write), .short_direct_call(short_call),
    .vector_req(vector_req), .vector_src(vector_src));
  mmd_top mmd_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_addr(core_addr),
    .core_valid(core_valid), .core_write(core_write), .short_direct_call(short_call),
    .vector_req(vector_req), .vector_src(vector_src), .region(region), .rom_sel(rom_sel),
    .rom_addr(rom_addr), .write_blocked(write_blocked), .call_fault(call_fault),
    .vector_addr(vector_addr), .vector_valid(vector_valid));
  initial begin
    hclk = 0;
    forever #20 hclk = ~hclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task ahb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task probe(input logic [15:0] a, input logic [3:0] r);
    mmd_core_model_inst.access(a, 1'b0, 1'b0);
    chk("region", 32'(region), 32'(r));
  endtask
  task t_reset;
    ahb(12'h000, 0, 0, rd);
    chk("rom size", rd, 32'h0000_00CF);
    ahb(12'h004, 0, 0, rd);
    chk("ram size", rd, 32'h0000_000C);
    ahb(12'h020, 0, 0, rd);
    chk("unmapped", rd, 32'h0);
    chk("bus answer", {30'h0, hreadyout, hresp}, 32'h2);
  endtask
  task t_regs;
    // ram sized while rom still at its reset code: flagged
    ahb(12'h004, 1, 32'h0A, rd);
    ahb(12'h010, 0, 0, rd);
    chk("order flag", rd, 32'h0001_DFFF);
    ahb(12'h010, 1, 32'h1, rd);
    ahb(12'h010, 0, 0, rd);
    chk("order clear", rd, 32'h0001_DFFE);
    probe(16'hF400, 4'h8);
    chk("ram not rom", 32'(rom_sel), 32'h0);
    ahb(12'h014, 1, 32'h0040, rd);
    ahb(12'h014, 0, 0, rd);
    chk("lookup", rd, 32'h0012_0040);
  endtask
  task t_flat;
    logic [7:0]  code [5];
    logic [15:0] lim [5];
    code = '{8'h04, 8'hC6, 8'hC8, 8'hCC, 8'hCF};
    lim = '{16'h3FFF, 16'h5FFF, 16'h7FFF, 16'hBFFF, 16'hEFFF};
    for (int i = 0; i < 5; i++) begin
      ahb(12'h000, 1, {24'h0, code[i]}, rd);
      probe(lim[i], 4'h6);
      mmd_core_model_inst.access(lim[i] + 16'h1, 0, 0);
      chk("above limit", 32'(rom_sel), 32'h0);
    end
  endtask
  task t_fixed;
    ahb(12'h00C, 1, 32'h0, rd);
    probe(16'h0000, 4'h1);
    probe(16'h003F, 4'h1);
    probe(16'h0040, 4'h2);
    probe(16'h007F, 4'h2);
    probe(16'h0080, 4'h3);
    probe(16'h0084, 4'h3);
    probe(16'h1080, 4'h6);
    probe(16'h0085, 4'h6);
    ahb(12'h00C, 1, 32'h9, rd);
    probe(16'h1080, 4'h3);
    probe(16'h1084, 4'h3);
    probe(16'h0085, 4'h4);
    probe(16'h108E, 4'h4);
    probe(16'h0800, 4'h5);
  endtask
  task t_vec;
    logic [4:0]  src [5];
    logic [15:0] slot [5];
    src = '{5'd0, 5'd1, 5'd2, 5'd25, 5'd31};
    slot = '{16'h0000, 16'h0004, 16'h0006, 16'h0034, 16'h0034};
    for (int i = 0; i < 5; i++) begin
      mmd_core_model_inst.vec(src[i]);
      chk("vector", {vector_valid, 15'h0, vector_addr}, {16'h8000, slot[i]});
    end
  endtask
  task t_bank;
    // order matters: control word before bank, whose six bank bit sets the limit
    ahb(12'h00C, 1, 32'h4, rd);
    ahb(12'h000, 1, 32'hCC, rd);
    ahb(12'h008, 1, 32'h2, rd);
    ahb(12'h008, 1, 32'h5, rd);
    ahb(12'h008, 0, 0, rd);
    chk("bank", rd, 32'h2);
    probe(16'h9000, 4'h7);
    chk("window", 32'(rom_addr), 32'h11000);
    probe(16'h7FFF, 4'h6);
    mmd_core_model_inst.access(16'hC000, 0, 0);
    chk("past window", 32'(rom_sel), 0);
    // six bank part: bank 5 now accepted
    ahb(12'h00C, 1, 32'h14, rd);
    ahb(12'h008, 1, 32'h5, rd);
    ahb(12'h008, 0, 0, rd);
    chk("six banks", rd, 32'h5);
    probe(16'h9000, 4'h7);
    chk("last bank", 32'(rom_addr), 32'h1D000);
  endtask
  task t_guard;
    ahb(12'h00C, 1, 32'h2, rd);
    mmd_core_model_inst.access(16'h0800, 0, 1);
    chk("call", 32'(call_fault), 0);
    mmd_core_model_inst.access(16'h1000, 0, 1);
    chk("call", 32'(call_fault), 1);
    mmd_core_model_inst.access(16'h0FFF, 1, 0);
    chk("blk", 32'(write_blocked), 1);
    mmd_core_model_inst.access(16'h1000, 1, 0);
    chk("blk", 32'(write_blocked), 0);
  endtask
  task t_again;
    // second reset in mid-run: sizes and control fall back
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(12'h000, 0, 0, rd);
    chk("rom size again", rd, 32'h0000_00CF);
    ahb(12'h004, 0, 0, rd);
    chk("ram size again", rd, 32'h0000_000C);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge hclk);
    bad_count++;
    wrap_up;
  end
  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    bad_count = 0;
    tests_run = 0;
    hresetn = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_flat;
    t_fixed;
    t_vec;
    t_bank;
    t_guard;
    t_again;
    wrap_up;
  end
endmodule
`default_nettype wire
